//--- bench/touch_timing_config_ctrl_tb_top.sv
// Testbench: registers, configuration outputs, alert events, hold and recalibration timing
`timescale 1ns/1ps
module touch_timing_config_ctrl_tb_top;
  typedef struct packed {logic [7:0] idx, wd; logic [3:0] be; logic [7:0] exp;} ttc_row_t;
  localparam int MS_CYC = 10;
  // Lane 0 disabled: write ignored, reset value read back
  localparam ttc_row_t ROWS [10] = '{
    '{8'h21, 8'hFF, 4'h0, 8'h07}, '{8'h22, 8'h00, 4'h0, 8'hA4}, '{8'h23, 8'h00, 4'h0, 8'h07},
    '{8'h44, 8'h00, 4'h0, 8'h40}, '{8'h21, 8'h05, 4'h1, 8'h05}, '{8'h22, 8'h0C, 4'h1, 8'h0C},
    '{8'h23, 8'h00, 4'h1, 8'h00}, '{8'h50, 8'hFF, 4'h1, 8'h00}, '{8'h74, 8'h06, 4'h1, 8'h06},
    '{8'h28, 8'hFF, 4'h1, 8'h07}};
  logic        mclk = 1'b0, rst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, active_low = 1'b1;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  be_s = 4'h0;
  logic [2:0]  touch = 3'h0, rf = 3'h0, emi = 3'h0, ssel, dzero, ltouch, lpol, lmir, recal, hold;
  logic        waitreq, spower, duty, alert_o, alert_oe, seen;
  int          num_errors = 0, checks_done = 0, n;
  int          cnt [4];
  ttc_top #(.MS_CYCLES(MS_CYC)) dut (
    .MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be_s), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .TOUCH_DET(touch), .RF_NOISE(rf), .EMI_NOISE(emi), .SAMPLE_SEL(ssel), .SENSE_POWER(spower),
    .DELTA_ZERO(dzero), .LINK_TOUCH(ltouch), .LINK_DUTY_EQUAL(duty), .LED_POLARITY(lpol),
    .LED_MIRROR(lmir), .RECAL_REQ(recal), .HOLD_EVENT(hold), .ALERT_O(alert_o), .ALERT_OE(alert_oe));
  ttc_host_model host (.alert_o(alert_o), .alert_oe(alert_oe), .active_low(active_low), .alert_seen(seen));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic results();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Request held until waitrequest is sampled low; one idle edge follows
  task automatic bus(input logic r, input logic [7:0] i, input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    addr <= {i, 2'b00};
    rd_s <= r;
    wr_s <= !r;
    wdata <= {24'h0, d};
    be_s <= be;
    do begin
      @(posedge mclk);
      k++;
      if (k > 20) begin
        num_errors++;
        results();
      end
    end while (waitreq !== 1'b0);
    rd = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    @(posedge mclk);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (ROWS[k]) begin
      bus(1'b0, ROWS[k].idx, ROWS[k].wd, ROWS[k].be);
      bus(1'b1, ROWS[k].idx, 8'h00, 4'hF);
      chk("register", {24'h0, ROWS[k].exp}, rd);
    end
    bus(1'b0, 8'h44, 8'h00, 4'h1);
    active_low <= 1'b0;
    chk("duty equal", 32'h1, 32'(duty));
    bus(1'b0, 8'h73, 8'h05, 4'h1);
    chk("mirror", 32'h5, 32'(lmir));
    rf <= 3'h1;
    emi <= 3'h2;
    repeat (5) @(posedge mclk);
    chk("rf delta zero", 32'h1, 32'(dzero[0]));
    bus(1'b1, 8'h0A, 8'h00, 4'hF);
    chk("noise both", 32'h3, rd);
    bus(1'b0, 8'h44, 8'h3C, 4'h1);
    bus(1'b1, 8'h0A, 8'h00, 4'hF);
    chk("noise rf only", 32'h1, rd);
    chk("rf filter off", 32'h0, 32'(dzero[0]));
    bus(1'b0, 8'h73, 8'h02, 4'h1);
    chk("mirror blocked", 32'h5, 32'(lmir));
    chk("polarity", 32'h2, 32'(lpol));
    rf <= 3'h0;
    emi <= 3'h0;
    bus(1'b0, 8'h44, 8'h80, 4'h1);
    bus(1'b0, 8'h00, 8'h00, 4'h1);
    chk("duty inverted", 32'h0, 32'(duty));
    touch <= 3'h1;
    repeat (5) @(posedge mclk);
    chk("press alert", 32'h1, 32'(seen));
    chk("link inverted", 32'h6, 32'(ltouch));
    bus(1'b0, 8'h00, 8'h00, 4'h1);
    chk("alert cleared", 32'h0, 32'(seen));
    touch <= 3'h0;
    repeat (5) @(posedge mclk);
    chk("release alert", 32'h1, 32'(seen));
    bus(1'b0, 8'h44, 8'h81, 4'h1);
    bus(1'b0, 8'h00, 8'h00, 4'h1);
    touch <= 3'h1;
    repeat (5) @(posedge mclk);
    bus(1'b0, 8'h00, 8'h00, 4'h1);
    touch <= 3'h0;
    repeat (5) @(posedge mclk);
    chk("release quiet", 32'h0, 32'(seen));
    // Threshold 35 ms and max hold 560 ms at ten cycles per ms
    bus(1'b0, 8'h20, 8'h28, 4'h1);
    touch <= 3'h1;
    repeat (330) @(posedge mclk);
    chk("hold early", 32'h0, 32'(hold));
    repeat (70) @(posedge mclk);
    chk("hold late", 32'h1, 32'(hold));
    bus(1'b1, 8'h03, 8'h00, 4'hF);
    chk("touch status", 32'h1, rd);
    bus(1'b1, 8'h0B, 8'h00, 4'hF);
    chk("hold status", 32'h1, rd);
    bus(1'b0, 8'h00, 8'h00, 4'h1);
    chk("alert cleared held", 32'h0, 32'(seen));
    n = 409;
    while (recal[0] !== 1'b1 && n < 7000) begin
      @(posedge mclk);
      n++;
    end
    chk("recal time", 32'h1, 32'(n >= 5580 && n <= 5620));
    // First repeat, 455 ms after the hold is recognised, comes before the 560 ms recalibration
    chk("repeat alert", 32'h1, 32'(seen));
    bus(1'b0, 8'h28, 8'h06, 4'h1);
    bus(1'b0, 8'h00, 8'h00, 4'h1);
    repeat (5200) @(posedge mclk);
    chk("no repeat alert", 32'h0, 32'(seen));
    chk("no hold event", 32'h0, 32'(hold));
    // Input 2 disabled, power hold off: one full sampling cycle from slot 1
    n = 0;
    while (ssel === 3'h1 && n < 800) begin
      @(posedge mclk);
      n++;
    end
    while (ssel !== 3'h1 && n < 800) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 800) begin
      num_errors++;
      results();
    end
    cnt = '{default: 0};
    repeat (ttc_pkg::CYCLE_MS * MS_CYC) begin
      cnt[0] += int'(spower === 1'b1);
      cnt[1] += int'(ssel === 3'h1);
      cnt[2] += int'(ssel === 3'h2);
      cnt[3] += int'(ssel === 3'h4);
      @(posedge mclk);
    end
    chk("powered cycles", 32'(3 * ttc_pkg::SLOT_MS * MS_CYC), 32'(cnt[0]));
    chk("slot 1 cycles", 32'(ttc_pkg::SLOT_MS * MS_CYC), 32'(cnt[1]));
    chk("slot 2 cycles", 32'h0, 32'(cnt[2]));
    chk("slot 3 cycles", 32'(ttc_pkg::SLOT_MS * MS_CYC), 32'(cnt[3]));
    chk("cycle restart", 32'h1, 32'(ssel));
    results();
  end
endmodule

//--- bench/ttc_host_model.sv
// Host side of the alert line: pulled-up wire and polarity-aware detector
`timescale 1ns/1ps
module ttc_host_model (
  input  wire logic alert_o,
  input  wire logic alert_oe,
  input  wire logic active_low,
  output logic      alert_seen
);
  logic pin;
  // Released open-drain line rests at the pull-up level
  assign pin        = alert_oe ? alert_o : 1'b1;
  assign alert_seen = active_low ? !pin : pin;
endmodule

//--- bench/ttc_properties.sv
// Checker: port-level properties of the touch timing control block
`timescale 1ns/1ps
module ttc_properties #(
  parameter int MS_CYCLES = ttc_pkg::MS_CYCLES,
  parameter int CYCLE_MS  = ttc_pkg::CYCLE_MS,
  parameter int SLOT_MS   = ttc_pkg::SLOT_MS
) (
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic [9:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [2:0]  SAMPLE_SEL,
  input wire logic        SENSE_POWER,
  input wire logic        LINK_DUTY_EQUAL,
  input wire logic [2:0]  LED_MIRROR,
  input wire logic [2:0]  RECAL_REQ,
  input wire logic        ALERT_O,
  input wire logic        ALERT_OE
);
  // ----------------------------------------------------------------
  // Shadow copies, updated on the same edge as the design registers
  // ----------------------------------------------------------------
  logic [7:0] idx, cfg2_q;
  logic [2:0] en_q;
  logic       wr_ok;
  assign idx   = AVS_ADDRESS[9:2];
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cfg2_q <= 8'h40;
      en_q   <= 3'h7;
    end else if (wr_ok && idx == 8'h44) begin
      cfg2_q <= AVS_WRITEDATA[7:0];
    end else if (wr_ok && idx == 8'h21) begin
      en_q <= AVS_WRITEDATA[2:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_req_open;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_wr(logic [7:0] i);
    wr_ok && idx == i;
  endsequence
  a_one_wait: assert property (s_req_open |=> !AVS_WAITREQUEST) else $error("waitrequest too long");
  a_duty_link: assert property (s_wr(8'h44) |=> LINK_DUTY_EQUAL == !$past(AVS_WRITEDATA[7]))
    else $error("duty equal not following invert bit");
  a_alert_pushpull: assert property (!cfg2_q[6] |-> ALERT_OE) else $error("alert not driven");
  a_alert_drain: assert property (cfg2_q[6] |-> !ALERT_O) else $error("open drain alert high");
  a_power_hold: assert property (cfg2_q[5] |-> SENSE_POWER) else $error("sensing powered down");
  a_mirror_copy: assert property (s_wr(8'h73) ##0 !cfg2_q[4] |=> LED_MIRROR == $past(AVS_WRITEDATA[2:0]))
    else $error("mirror not copied");
  a_mirror_block: assert property (s_wr(8'h73) ##0 cfg2_q[4] |=> $stable(LED_MIRROR))
    else $error("mirror changed while blocked");
  a_sample_gate: assert property ($onehot0(SAMPLE_SEL) && (SAMPLE_SEL & ~en_q) == 3'h0)
    else $error("disabled input sampled");
  a_recal_pulse: assert property (RECAL_REQ != 3'h0 |=> (RECAL_REQ & $past(RECAL_REQ)) == 3'h0)
    else $error("recalibration request longer than one cycle");
endmodule
bind ttc_top ttc_properties #(.MS_CYCLES(MS_CYCLES), .CYCLE_MS(CYCLE_MS), .SLOT_MS(SLOT_MS)) u_props (
  .MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SAMPLE_SEL(SAMPLE_SEL), .SENSE_POWER(SENSE_POWER), .LINK_DUTY_EQUAL(LINK_DUTY_EQUAL),
  .LED_MIRROR(LED_MIRROR), .RECAL_REQ(RECAL_REQ), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE)
);

//--- verilog/ttc_pkg.sv
// Package: register map, reset values and timing constants of the touch timing control block
package ttc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS       = 8'h00;
  localparam logic [7:0] IDX_TOUCH_STATUS = 8'h03;
  localparam logic [7:0] IDX_NOISE_STATUS = 8'h0A;
  localparam logic [7:0] IDX_HOLD_STATUS  = 8'h0B;
  localparam logic [7:0] IDX_GLOBAL_CFG1  = 8'h20;
  localparam logic [7:0] IDX_INPUT_EN     = 8'h21;
  localparam logic [7:0] IDX_TIMING_CFG   = 8'h22;
  localparam logic [7:0] IDX_PRESS_HOLD   = 8'h23;
  localparam logic [7:0] IDX_REPEAT_EN    = 8'h28;
  localparam logic [7:0] IDX_GLOBAL_CFG2  = 8'h44;
  localparam logic [7:0] IDX_LED_POLARITY = 8'h73;
  localparam logic [7:0] IDX_LED_MIRROR   = 8'h74;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GLOBAL_CFG1  = 8'h20;
  localparam logic [7:0] RST_GLOBAL_CFG2  = 8'h40;
  localparam logic [7:0] RST_INPUT_EN     = 8'h07;
  localparam logic [7:0] RST_TIMING_CFG   = 8'hA4;
  localparam logic [7:0] RST_PRESS_HOLD   = 8'h07;
  localparam logic [7:0] RST_REPEAT_EN    = 8'h07;
  localparam logic [7:0] RST_LED          = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LINK_TRANSITION_INVERT = 7;
  localparam int BIT_ALERT_POLARITY_SELECT  = 6;
  localparam int BIT_SENSE_POWER_HOLD       = 5;
  localparam int BIT_POLARITY_MIRROR_BLOCK  = 4;
  localparam int BIT_RF_ONLY_NOISE_REPORT   = 3;
  localparam int BIT_RF_FILTER_DISABLE      = 2;
  localparam int BIT_RELEASE_IRQ_SUPPRESS   = 0;
  localparam int BIT_ANALOG_FILTER_DISABLE  = 4;
  localparam int BIT_MAX_HOLD_RECAL_ENABLE  = 3;
  localparam int BIT_IRQ_FLAG               = 0;
  localparam int MAX_HOLD_LSB               = 4;
  localparam int REPEAT_INTERVAL_LSB        = 0;
  localparam int PRESS_HOLD_LSB             = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_MS       = 35;
  localparam int CYCLE_MS      = 70;
  localparam int SLOT_MS       = 5;

  // Max hold time in ms, indexed by field code
  localparam logic [15:0][13:0] MAX_HOLD_MS = {
    14'd11200, 14'd10080, 14'd8906, 14'd7840, 14'd6720, 14'd5600, 14'd4480, 14'd3920,
    14'd3360,  14'd2800,  14'd2240, 14'd1680, 14'd1400, 14'd1120, 14'd840,  14'd560
  };

  typedef enum logic [1:0] {
    PH_CONVERT = 2'b01,
    PH_REST    = 2'b10
  } ttc_phase_t;

endpackage

//--- verilog/ttc_top.sv
// Touch timing and global configuration control with Avalon-MM register access
// How it works
// - Invert clear: linked transition forces min duty to max; set: touch signal inverted.
// - Alert polarity 0: active high push-pull; 1 (default): active low open drain.
// - Power hold clear: sensing powers down after conversions; set: stays powered.
// - Block clear: polarity writes copy into mirror; set: mirror left untouched.
// - Report clear: status shows RF and EMI noise; set: only RF, EMI still blocks.
// - RF filter enabled: RF noise zeroes delta; disabled: RF noise never blocks.
// - Release suppress clear: irq on press, release, repeat; set: no release irq.
// - Three sample enables include or exclude each input; reset all enabled.
// - Sampling cycle length is constant whatever inputs are enabled.
// - Max hold field bits 7..4, reset 1010b, shared, sets recalibration time.
// - Max hold codes decode to 560 ms through 11200 ms per table.
// - Repeat field bits 3..0, reset 0100b, interval 35 ms times code plus one.
// - Auto-repeat touch beyond threshold is press-and-hold, otherwise ordinary touch.
// - Press-and-hold threshold field bits 3..0, reset 0111b, 35 ms steps.
// - Max hold recalibration only when its global enable bit is set.
// - Repeat disabled input interrupts only on touch and release.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module ttc_top #(
  parameter int MS_CYCLES = ttc_pkg::MS_CYCLES,
  parameter int CYCLE_MS  = ttc_pkg::CYCLE_MS,
  parameter int SLOT_MS   = ttc_pkg::SLOT_MS
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [2:0]  TOUCH_DET,
  input  wire logic [2:0]  RF_NOISE,
  input  wire logic [2:0]  EMI_NOISE,
  output logic      [2:0]  SAMPLE_SEL,
  output logic             SENSE_POWER,
  output logic      [2:0]  DELTA_ZERO,
  output logic      [2:0]  LINK_TOUCH,
  output logic             LINK_DUTY_EQUAL,
  output logic      [2:0]  LED_POLARITY,
  output logic      [2:0]  LED_MIRROR,
  output logic      [2:0]  RECAL_REQ,
  output logic      [2:0]  HOLD_EVENT,
  output logic             ALERT_O,
  output logic             ALERT_OE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]             touch_m;
    logic [2:0]             touch_s;
    logic [2:0]             rf_m;
    logic [2:0]             rf_s;
    logic [2:0]             emi_m;
    logic [2:0]             emi_s;
    logic [7:0]             cfg1;
    logic [7:0]             cfg2;
    logic [7:0]             input_en;
    logic [7:0]             timing;
    logic [7:0]             press_hold;
    logic [7:0]             repeat_en;
    logic [7:0]             polarity;
    logic [7:0]             mirror;
    logic                   irq;
    logic                   ack;
    logic [31:0]            rdata;
    logic [16:0]            div;
    logic [7:0]             cyc_ms;
    ttc_pkg::ttc_phase_t    phase;
    logic [2:0]             touch;
    logic [2:0]             held;
    logic [2:0]             recal;
    logic [2:0][13:0]       hold_ms;
    logic [2:0][9:0]        rpt_ms;
  } ttc_state_t;

  ttc_state_t s_q;
  ttc_state_t s_d;

  logic       ms_tick;
  logic [2:0] blocked;
  logic [2:0] valid_touch;
  logic [2:0] noise_seen;
  logic [7:0] idx;
  logic       wr_now;
  logic [13:0] max_ms;
  logic [13:0] hold_thr;
  logic [9:0]  rpt_thr;

  // Only lane zero carries register bits; a write without it is dropped
  assign idx     = AVS_ADDRESS[9:2];
  assign ms_tick = (s_q.div == 17'(MS_CYCLES - 1));
  assign wr_now  = AVS_WRITE & s_q.ack & AVS_BYTEENABLE[0];
  assign max_ms  = ttc_pkg::MAX_HOLD_MS[s_q.timing[ttc_pkg::MAX_HOLD_LSB +: 4]];
  assign hold_thr = 14'((s_q.press_hold[ttc_pkg::PRESS_HOLD_LSB +: 4] + 5'd1) * ttc_pkg::STEP_MS);
  assign rpt_thr  = 10'((s_q.timing[ttc_pkg::REPEAT_INTERVAL_LSB +: 4] + 5'd1) * ttc_pkg::STEP_MS);

  // ----------------------------------------------------------------
  // Noise handling and touch qualification
  // ----------------------------------------------------------------
  // EMI always blocks unless the analog filter is off; RF blocks unless its filter is off
  assign blocked = (s_q.rf_s & {3{~s_q.cfg2[ttc_pkg::BIT_RF_FILTER_DISABLE]}})
                 | (s_q.emi_s & {3{~s_q.cfg1[ttc_pkg::BIT_ANALOG_FILTER_DISABLE]}});
  assign noise_seen = s_q.rf_s | (s_q.emi_s & {3{~s_q.cfg2[ttc_pkg::BIT_RF_ONLY_NOISE_REPORT]}});
  assign valid_touch = s_q.touch_s & s_q.input_en[2:0] & ~blocked;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic event_any;
    logic press;
    logic release_ev;
    logic repeat_ev;
    event_any = 1'b0;
    press      = 1'b0;
    release_ev = 1'b0;
    repeat_ev  = 1'b0;
    s_d = s_q;
    // Pin flags pass two stages; only the second stage feeds the logic
    s_d.touch_m = TOUCH_DET;
    s_d.touch_s = s_q.touch_m;
    s_d.rf_m    = RF_NOISE;
    s_d.rf_s    = s_q.rf_m;
    s_d.emi_m   = EMI_NOISE;
    s_d.emi_s   = s_q.emi_m;
    s_d.recal   = 3'h0;

    // One ms time base shared by the sampling cycle and every touch timer
    // The divider runs free, so a press meets its first tick 1 to MS_CYCLES clocks later
    s_d.div = ms_tick ? 17'h0 : s_q.div + 17'h1;

    // Cycle length is fixed; disabled inputs simply leave their slot empty
    if (ms_tick) begin
      if (s_q.cyc_ms == 8'(CYCLE_MS - 1)) begin
        s_d.cyc_ms = 8'h0;
        s_d.phase  = ttc_pkg::PH_CONVERT;
      end else begin
        s_d.cyc_ms = s_q.cyc_ms + 8'h1;
        if (s_q.cyc_ms == 8'(3 * SLOT_MS - 1)) begin
          s_d.phase = ttc_pkg::PH_REST;
        end
      end
    end

    // Per-input touch tracking
    for (int i = 0; i < 3; i++) begin
      press      = valid_touch[i] & ~s_q.touch[i];
      release_ev = ~valid_touch[i] & s_q.touch[i];
      repeat_ev  = 1'b0;
      s_d.touch[i] = valid_touch[i];
      if (press) begin
        s_d.hold_ms[i] = 14'h0;
        s_d.rpt_ms[i]  = 10'h0;
        s_d.held[i]    = 1'b0;
      end else if (release_ev) begin
        s_d.held[i] = 1'b0;
      end else if (s_q.touch[i] && ms_tick) begin
        // Saturates so a touch held without recalibration never wraps to a short one
        if (s_q.hold_ms[i] != 14'h3FFF) begin
          s_d.hold_ms[i] = s_q.hold_ms[i] + 14'h1;
        end
        // Press-and-hold only for inputs with auto repeat
        // Strictly greater: a touch of exactly the threshold stays an ordinary touch
        if (s_q.repeat_en[i] && s_q.hold_ms[i] > hold_thr) begin
          s_d.held[i] = 1'b1;
        end
        // Repeat spacing counts from recognition of the hold, not from the press
        if (s_q.held[i] && s_q.repeat_en[i]) begin
          if (s_q.rpt_ms[i] >= rpt_thr - 10'h1) begin
            s_d.rpt_ms[i] = 10'h0;
            repeat_ev     = 1'b1;
          end else begin
            s_d.rpt_ms[i] = s_q.rpt_ms[i] + 10'h1;
          end
        end
        // Recalibration restarts the touch timers as a fresh touch would
        if (s_q.cfg1[ttc_pkg::BIT_MAX_HOLD_RECAL_ENABLE] && s_q.hold_ms[i] >= max_ms - 14'h1) begin
          s_d.recal[i]   = 1'b1;
          s_d.hold_ms[i] = 14'h0;
          s_d.rpt_ms[i]  = 10'h0;
          s_d.held[i]    = 1'b0;
        end
      end
      // Events of all inputs merge into one flag; touch status tells the source
      event_any = event_any | press | repeat_ev
                | (release_ev & ~s_q.cfg2[ttc_pkg::BIT_RELEASE_IRQ_SUPPRESS]);
    end

    // Register writes take effect on the edge where waitrequest is low
    if (wr_now) begin
      case (idx)
        ttc_pkg::IDX_GLOBAL_CFG1:  s_d.cfg1       = AVS_WRITEDATA[7:0];
        ttc_pkg::IDX_GLOBAL_CFG2:  s_d.cfg2       = AVS_WRITEDATA[7:0];
        ttc_pkg::IDX_INPUT_EN:     s_d.input_en   = {5'h0, AVS_WRITEDATA[2:0]};
        ttc_pkg::IDX_TIMING_CFG:   s_d.timing     = AVS_WRITEDATA[7:0];
        ttc_pkg::IDX_PRESS_HOLD:   s_d.press_hold = {4'h0, AVS_WRITEDATA[3:0]};
        ttc_pkg::IDX_REPEAT_EN:    s_d.repeat_en  = {5'h0, AVS_WRITEDATA[2:0]};
        ttc_pkg::IDX_LED_MIRROR:   s_d.mirror     = {5'h0, AVS_WRITEDATA[2:0]};
        ttc_pkg::IDX_LED_POLARITY: begin
          s_d.polarity = {5'h0, AVS_WRITEDATA[2:0]};
          if (!s_q.cfg2[ttc_pkg::BIT_POLARITY_MIRROR_BLOCK]) begin
            s_d.mirror = {5'h0, AVS_WRITEDATA[2:0]};
          end
        end
        // Writing one leaves the flag alone, so a read-modify-write cannot lose an event
        ttc_pkg::IDX_STATUS: begin
          if (!AVS_WRITEDATA[ttc_pkg::BIT_IRQ_FLAG]) begin
            s_d.irq = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // An event in the clearing cycle keeps the flag set
    if (event_any) begin
      s_d.irq = 1'b1;
    end

    // Bus answer: one wait cycle, read data captured when the answer is given
    // The wait cycle gives the read mux a full clock, at two cycles per access
    s_d.ack = (AVS_READ | AVS_WRITE) & ~s_q.ack;
    if (AVS_READ && !s_q.ack) begin
      case (idx)
        ttc_pkg::IDX_STATUS:       s_d.rdata = {31'h0, s_q.irq};
        ttc_pkg::IDX_TOUCH_STATUS: s_d.rdata = {29'h0, s_q.touch};
        ttc_pkg::IDX_NOISE_STATUS: s_d.rdata = {29'h0, noise_seen};
        ttc_pkg::IDX_HOLD_STATUS:  s_d.rdata = {29'h0, s_q.held};
        ttc_pkg::IDX_GLOBAL_CFG1:  s_d.rdata = {24'h0, s_q.cfg1};
        ttc_pkg::IDX_GLOBAL_CFG2:  s_d.rdata = {24'h0, s_q.cfg2};
        ttc_pkg::IDX_INPUT_EN:     s_d.rdata = {24'h0, s_q.input_en};
        ttc_pkg::IDX_TIMING_CFG:   s_d.rdata = {24'h0, s_q.timing};
        ttc_pkg::IDX_PRESS_HOLD:   s_d.rdata = {24'h0, s_q.press_hold};
        ttc_pkg::IDX_REPEAT_EN:    s_d.rdata = {24'h0, s_q.repeat_en};
        ttc_pkg::IDX_LED_POLARITY: s_d.rdata = {24'h0, s_q.polarity};
        ttc_pkg::IDX_LED_MIRROR:   s_d.rdata = {24'h0, s_q.mirror};
        default:                   s_d.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      // Synchronisers clear with the rest, so no false press follows reset
      s_q            <= '0;
      s_q.cfg1       <= ttc_pkg::RST_GLOBAL_CFG1;
      s_q.cfg2       <= ttc_pkg::RST_GLOBAL_CFG2;
      s_q.input_en   <= ttc_pkg::RST_INPUT_EN;
      s_q.timing     <= ttc_pkg::RST_TIMING_CFG;
      s_q.press_hold <= ttc_pkg::RST_PRESS_HOLD;
      s_q.repeat_en  <= ttc_pkg::RST_REPEAT_EN;
      s_q.polarity   <= ttc_pkg::RST_LED;
      s_q.mirror     <= ttc_pkg::RST_LED;
      s_q.phase      <= ttc_pkg::PH_CONVERT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    // A disabled input keeps its slot empty, so the cycle never shortens
    SAMPLE_SEL = 3'h0;
    if (s_q.phase == ttc_pkg::PH_CONVERT) begin
      if (s_q.cyc_ms < 8'(SLOT_MS)) begin
        SAMPLE_SEL = 3'h1 & s_q.input_en[2:0];
      end else if (s_q.cyc_ms < 8'(2 * SLOT_MS)) begin
        SAMPLE_SEL = 3'h2 & s_q.input_en[2:0];
      end else begin
        SAMPLE_SEL = 3'h4 & s_q.input_en[2:0];
      end
    end
  end

  // Resting part of the cycle powers sensing down unless held on
  assign SENSE_POWER     = (s_q.phase == ttc_pkg::PH_CONVERT)
                         | s_q.cfg2[ttc_pkg::BIT_SENSE_POWER_HOLD];
  // Delta is forced to zero by whichever noise currently blocks the input
  assign DELTA_ZERO      = blocked;
  // Inversion reaches only what the LED link sees, never the touch status
  assign LINK_TOUCH      = s_q.touch ^ {3{s_q.cfg2[ttc_pkg::BIT_LINK_TRANSITION_INVERT]}};
  assign LINK_DUTY_EQUAL = ~s_q.cfg2[ttc_pkg::BIT_LINK_TRANSITION_INVERT];
  assign LED_POLARITY    = s_q.polarity[2:0];
  assign LED_MIRROR      = s_q.mirror[2:0];
  assign RECAL_REQ       = s_q.recal;
  assign HOLD_EVENT      = s_q.held;
  // Open drain pulls low only while asserted; push-pull drives the level always
  assign ALERT_O  = s_q.cfg2[ttc_pkg::BIT_ALERT_POLARITY_SELECT] ? 1'b0 : s_q.irq;
  assign ALERT_OE = s_q.cfg2[ttc_pkg::BIT_ALERT_POLARITY_SELECT] ? s_q.irq : 1'b1;
  assign AVS_READDATA    = s_q.rdata;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_q.ack;

endmodule
